/* hw/ptr_pkg.sv */
// shared constants for the pass-through passive burst read link
package ptr_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int BE_W = 4;
	localparam int REGADR_W = 5;
	localparam int NUM_W = 2;
	localparam int CNT_W = 8;
	// register address lines [6:2] selecting the pass-through data register
	localparam logic [4:0] DATA_REG_ADR = 5'h0b;
	// region number reset value and region-one code
	localparam logic [1:0] REGION_RST = 2'h0;
	localparam logic [1:0] REGION_ONE = 2'h1;
	// most words handed to the add-on per packet without prefetch
	localparam logic [7:0] PACKET_MAX = 8'h02;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [3:0] BE_NONE_N = 4'hf;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// fifo depth in words
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	localparam logic [2:0] PTR_ZERO = 3'h0;
	localparam logic [2:0] PTR_ONE = 3'h1;
endpackage : ptr_pkg

/* hw/ptr_link_if.sv */
// add-on bus between the bridge end and the add-on user end
`timescale 1ns/10ps
interface ptr_link_if;
	logic access_attention_n;
	logic multi_phase_flag_n;
	logic [ptr_pkg::NUM_W-1:0] region_number;
	logic access_is_write;
	logic [ptr_pkg::BE_W-1:0] pending_byte_lanes_n;
	logic address_fetch_n;
	logic addon_phase_done_n;
	logic [ptr_pkg::BE_W-1:0] byte_enables_n;
	logic [ptr_pkg::REGADR_W-1:0] reg_adr;
	logic select_n;
	logic wr_n;
	// shared data bus, split by driver
	logic [ptr_pkg::DATA_W-1:0] dq_dev_o;
	logic dq_dev_oe;
	logic [ptr_pkg::DATA_W-1:0] dq_usr_o;
	logic dq_usr_oe;
	logic [ptr_pkg::DATA_W-1:0] dq;
	// resolved wire level; the bridge drive wins on contention, float reads as zero
	assign dq = dq_dev_oe ? dq_dev_o : (dq_usr_oe ? dq_usr_o : '0);

	modport dev (
		output access_attention_n, multi_phase_flag_n, region_number,
		output access_is_write, pending_byte_lanes_n, dq_dev_o, dq_dev_oe,
		input address_fetch_n, addon_phase_done_n, byte_enables_n,
		input reg_adr, select_n, wr_n, dq
	);
	modport usr (
		input access_attention_n, multi_phase_flag_n, region_number,
		input access_is_write, pending_byte_lanes_n, dq,
		output address_fetch_n, addon_phase_done_n, byte_enables_n,
		output reg_adr, select_n, wr_n, dq_usr_o, dq_usr_oe
	);
endinterface : ptr_link_if

/* hw/ptr_word_fifo.sv */
// small word fifo used as the pass-through read fifo
`timescale 1ns/10ps
module ptr_word_fifo #(
	parameter int WIDTH = ptr_pkg::DATA_W,
	parameter int DEPTH = ptr_pkg::FIFO_DEPTH,
	parameter int AW = ptr_pkg::FIFO_AW
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// fill side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	output logic full,
	// drain side
	input wire logic pop,
	output logic [WIDTH-1:0] pop_data,
	output logic empty
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;
	logic do_push;
	logic do_pop;

	////////////////////////////////////////////////////////////////////
	// extra pointer bit tells full from empty
	assign empty = (wr_ptr_q == rd_ptr_q);
	assign full = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && !empty;
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign pop_data = mem[rd_ptr_q[AW-1:0]];

	// storage, no reset needed on data
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wr_ptr_q[AW-1:0]] <= push_data;
		end
	end

	// pointers
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end
endmodule : ptr_word_fifo

/* hw/ptr_bridge_end.sv */
// bridge end: pass-through passive burst read toward add-on logic
`timescale 1ns/10ps
module ptr_bridge_end #(
	parameter int PACKET_WORDS = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// host-side request, one-cycle pulse
	input wire logic host_req,
	input wire logic [ptr_pkg::ADDR_W-1:0] host_addr,
	input wire logic host_region_hit,
	input wire logic [ptr_pkg::NUM_W-1:0] host_region,
	input wire logic [ptr_pkg::CNT_W-1:0] host_words,
	input wire logic [ptr_pkg::BE_W-1:0] host_first_be_n,
	input wire logic [ptr_pkg::BE_W-1:0] host_next_be_n,
	input wire logic prefetch_en,
	output logic host_busy,
	// host-side drain of the read fifo
	input wire logic host_pop,
	output logic [ptr_pkg::DATA_W-1:0] host_data,
	output logic host_data_valid,
	// add-on link
	ptr_link_if.dev link
);
	typedef enum logic [1:0] {PTR_IDLE, PTR_ANNOUNCE, PTR_PHASE, PTR_GAP}
		ptr_state_t;
	ptr_state_t state_q;
	logic [ptr_pkg::ADDR_W-1:0] captured_address_reg_q;
	logic [ptr_pkg::CNT_W-1:0] left_q;
	logic [ptr_pkg::CNT_W-1:0] pkt_left_q;
	logic [ptr_pkg::BE_W-1:0] next_be_q;
	logic attn_n_q;
	logic burst_n_q;
	logic [ptr_pkg::NUM_W-1:0] region_q;
	logic [ptr_pkg::BE_W-1:0] lanes_n_q;
	logic data_reg_wr;
	logic phase_done;
	logic fifo_full;
	logic fifo_empty;
	logic [ptr_pkg::CNT_W-1:0] pkt_size;

	////////////////////////////////////////////////////////////////////
	// sampled handshakes, all active low
	assign data_reg_wr = !link.wr_n && !link.select_n &&
		(link.reg_adr == ptr_pkg::DATA_REG_ADR);
	assign phase_done = (state_q == PTR_PHASE) &&
		!link.addon_phase_done_n;
	assign host_busy = (state_q != PTR_IDLE);
	assign host_data_valid = !fifo_empty;

	// packet size: full burst with prefetch, else capped
	always_comb begin
		pkt_size = left_q;
		if (!prefetch_en && (left_q > PACKET_WORDS[ptr_pkg::CNT_W-1:0])) begin
			pkt_size = PACKET_WORDS[ptr_pkg::CNT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// access sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= PTR_IDLE;
			left_q <= ptr_pkg::CNT_ZERO;
			pkt_left_q <= ptr_pkg::CNT_ZERO;
		end else begin
			unique case (state_q)
				PTR_IDLE: begin
					if (host_req && host_region_hit &&
						host_words != ptr_pkg::CNT_ZERO) begin
						left_q <= host_words;
						state_q <= PTR_ANNOUNCE;
					end
				end
				PTR_ANNOUNCE: begin
					pkt_left_q <= pkt_size;
					state_q <= PTR_PHASE;
				end
				PTR_PHASE: begin
					if (phase_done) begin
						left_q <= left_q - ptr_pkg::CNT_ONE;
						pkt_left_q <= pkt_left_q - ptr_pkg::CNT_ONE;
						if (pkt_left_q == ptr_pkg::CNT_ONE) begin
							// gap cycle keeps a new access off for a clock
							state_q <= PTR_GAP;
						end
					end
				end
				PTR_GAP: begin
					// more words left: next packet after the gap
					state_q <= (left_q != ptr_pkg::CNT_ZERO) ?
						PTR_ANNOUNCE : PTR_IDLE;
				end
			endcase
		end
	end

	// address capture and lane template
	always_ff @(posedge clock) begin
		if (rst) begin
			captured_address_reg_q <= ptr_pkg::WORD_ZERO;
			region_q <= ptr_pkg::REGION_RST;
			next_be_q <= ptr_pkg::BE_NONE_N;
		end else if (state_q == PTR_IDLE && host_req && host_region_hit) begin
			captured_address_reg_q <= host_addr;
			region_q <= host_region;
			next_be_q <= host_next_be_n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status outputs, registered so they appear one edge later
	always_ff @(posedge clock) begin
		if (rst) begin
			attn_n_q <= 1'b1;
			burst_n_q <= 1'b1;
			lanes_n_q <= ptr_pkg::BE_NONE_N;
		end else begin
			if (state_q == PTR_IDLE && host_req && host_region_hit) begin
				lanes_n_q <= host_first_be_n;
			end else if (phase_done) begin
				lanes_n_q <= next_be_q;
			end
			if (state_q == PTR_ANNOUNCE) begin
				attn_n_q <= 1'b0;
				burst_n_q <= !(pkt_size > ptr_pkg::CNT_ONE);
			end else if (phase_done) begin
				// second-to-last done leaves one phase outstanding
				if (pkt_left_q == ptr_pkg::PACKET_MAX) begin
					burst_n_q <= 1'b1;
				end
				if (pkt_left_q == ptr_pkg::CNT_ONE) begin
					attn_n_q <= 1'b1;
					burst_n_q <= 1'b1;
				end
			end
		end
	end

	assign link.access_attention_n = attn_n_q;
	assign link.multi_phase_flag_n = burst_n_q;
	assign link.region_number = region_q;
	assign link.access_is_write = 1'b0;
	assign link.pending_byte_lanes_n = lanes_n_q;

	// address fetch is a plain combinational path, no clock
	assign link.dq_dev_oe = !link.address_fetch_n;
	assign link.dq_dev_o = captured_address_reg_q;

	////////////////////////////////////////////////////////////////////
	// read fifo; pushes only on a real strobe, so waits store nothing
	ptr_word_fifo #(
		.WIDTH(ptr_pkg::DATA_W),
		.DEPTH(ptr_pkg::FIFO_DEPTH),
		.AW(ptr_pkg::FIFO_AW)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.push(data_reg_wr && (state_q == PTR_PHASE)),
		.push_data(link.dq),
		.full(fifo_full),
		.pop(host_pop),
		.pop_data(host_data),
		.empty(fifo_empty)
	);
endmodule : ptr_bridge_end

/* hw/ptr_addon_end.sv */
// add-on end: services pass-through burst reads from user words
`timescale 1ns/10ps
module ptr_addon_end (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// user word source
	input wire logic src_valid,
	input wire logic [ptr_pkg::DATA_W-1:0] src_data,
	output logic src_ready,
	input wire logic want_address,
	// captured access info
	output logic [ptr_pkg::ADDR_W-1:0] got_address,
	output logic [ptr_pkg::NUM_W-1:0] got_region,
	// add-on link
	ptr_link_if.usr link
);
	typedef enum logic [2:0] {AO_IDLE, AO_FETCH, AO_TURN, AO_DATA, AO_DONE}
		ao_state_t;
	ao_state_t state_q;
	logic [ptr_pkg::ADDR_W-1:0] addr_q;
	logic [ptr_pkg::NUM_W-1:0] region_q;
	logic last_q;
	logic [ptr_pkg::DATA_W-1:0] dq_q;
	logic drive_q;
	logic attn;
	logic go;

	////////////////////////////////////////////////////////////////////
	assign attn = !link.access_attention_n;
	// a word goes out when data is ready; else a wait state.
	// a phase completing while burst is seen high was the last one,
	// so no further word may be taken then
	assign go = (state_q == AO_DATA) && src_valid &&
		!(drive_q && (last_q || link.multi_phase_flag_n));
	assign src_ready = go;

	// sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= AO_IDLE;
			last_q <= 1'b0;
		end else begin
			unique case (state_q)
				AO_IDLE: begin
					if (attn && !link.access_is_write) begin
						last_q <= link.multi_phase_flag_n;
						state_q <= want_address ? AO_FETCH : AO_DATA;
					end
				end
				AO_FETCH: state_q <= AO_TURN;
				AO_TURN: state_q <= AO_DATA;
				AO_DATA: begin
					if (link.multi_phase_flag_n) begin
						last_q <= 1'b1;
					end
					// burst high at a completing phase: that word ended it;
					// seen during a wait, one more transfer is still owed
					if (drive_q && (last_q || link.multi_phase_flag_n)) begin
						state_q <= AO_DONE;
					end
				end
				AO_DONE: begin
					// hold off until the bridge drops attention
					if (!attn) begin
						state_q <= AO_IDLE;
					end
				end
			endcase
		end
	end

	// address latch and region
	always_ff @(posedge clock) begin
		if (rst) begin
			addr_q <= ptr_pkg::WORD_ZERO;
			region_q <= ptr_pkg::REGION_RST;
		end else begin
			if (state_q == AO_IDLE && attn) begin
				region_q <= link.region_number;
			end
			if (state_q == AO_FETCH) begin
				addr_q <= link.dq;
			end
		end
	end

	// registered write data and drive enable
	always_ff @(posedge clock) begin
		if (rst) begin
			dq_q <= ptr_pkg::WORD_ZERO;
			drive_q <= 1'b0;
		end else begin
			dq_q <= src_data;
			drive_q <= go;
		end
	end

	assign got_address = addr_q;
	assign got_region = region_q;
	assign link.address_fetch_n = !(state_q == AO_FETCH);
	// strobe, select, address and ready move together
	assign link.wr_n = !drive_q;
	assign link.addon_phase_done_n = !drive_q;
	assign link.select_n = !drive_q;
	assign link.reg_adr = drive_q ? ptr_pkg::DATA_REG_ADR : '0;
	assign link.byte_enables_n = drive_q ?
		link.pending_byte_lanes_n : ptr_pkg::BE_NONE_N;
	assign link.dq_usr_oe = drive_q;
	assign link.dq_usr_o = dq_q;
endmodule : ptr_addon_end

/* tb/ptr_link_assertions.sv */
// concurrent checks on the add-on link between the two ends
`timescale 1ns/10ps
module ptr_link_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bridge end outputs
	input wire logic access_attention_n,
	input wire logic multi_phase_flag_n,
	input wire logic access_is_write,
	input wire logic [ptr_pkg::BE_W-1:0] pending_byte_lanes_n,
	input wire logic dq_dev_oe,
	// add-on end outputs
	input wire logic address_fetch_n,
	input wire logic addon_phase_done_n,
	input wire logic [ptr_pkg::REGADR_W-1:0] reg_adr,
	input wire logic select_n,
	input wire logic wr_n,
	input wire logic dq_usr_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// status relations; lanes may only move on a completed phase
	read_dir_a: assert property (!access_attention_n |-> !access_is_write)
		else $error("direction not read during access");
	burst_attn_a: assert property (!multi_phase_flag_n |-> !access_attention_n)
		else $error("burst without attention");
	burst_drop_a: assert property ($rose(multi_phase_flag_n) |-> $past(addon_phase_done_n) == 1'b0)
		else $error("burst dropped without a completed phase");
	attn_drop_a: assert property (!access_attention_n && multi_phase_flag_n && !addon_phase_done_n |=> access_attention_n)
		else $error("attention held after final phase");
	lanes_move_a: assert property (!access_attention_n && $past(access_attention_n) == 1'b0 && $changed(pending_byte_lanes_n) |-> $past(addon_phase_done_n) == 1'b0)
		else $error("lanes moved in a wait state");
	ready_attn_a: assert property (!addon_phase_done_n |-> !access_attention_n)
		else $error("ready outside an access");
	// bus ownership: address is asynchronous, one turnaround after it
	fetch_drive_a: assert property (dq_dev_oe == !address_fetch_n)
		else $error("address drive not following fetch");
	turn_around_a: assert property (!address_fetch_n |-> !dq_usr_oe ##1 !dq_usr_oe)
		else $error("add-on drove bus without turnaround");
	strobe_qual_a: assert property (!wr_n |-> !select_n && reg_adr == ptr_pkg::DATA_REG_ADR && !addon_phase_done_n && dq_usr_oe)
		else $error("strobe without full qualification");
	final_release_a: assert property ($rose(access_attention_n) |-> ##[0:1] (wr_n && select_n && addon_phase_done_n))
		else $error("add-on kept driving after final word");
endmodule : ptr_link_assertions

/* tb/passthru_passive_burst_read_test.sv */
// self-checking bench joining the bridge end and the add-on end
`timescale 1ns/10ps
module passthru_passive_burst_read_test;
	localparam logic [31:0] WORD_BASE = 32'ha5c3_0000;
	logic clock, rst, host_req, host_region_hit, prefetch_en, host_pop;
	logic host_busy, host_data_valid, src_valid, src_ready, want_address;
	logic stall, took, attn_q;
	logic [31:0] host_addr, host_data, src_data, got_address;
	logic [1:0] host_region, got_region;
	logic [7:0] host_words;
	int fail_count, samples_checked, popped, packets;
	ptr_link_if link ();
	ptr_bridge_end i_ptr_bridge_end (.clock(clock), .rst(rst),
		.host_req(host_req), .host_addr(host_addr),
		.host_region_hit(host_region_hit), .host_region(host_region),
		.host_words(host_words), .host_first_be_n(4'h2),
		.host_next_be_n(4'h0), .prefetch_en(prefetch_en),
		.host_busy(host_busy), .host_pop(host_pop), .host_data(host_data),
		.host_data_valid(host_data_valid), .link(link));
	ptr_addon_end i_ptr_addon_end (.clock(clock), .rst(rst),
		.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
		.want_address(want_address), .got_address(got_address),
		.got_region(got_region), .link(link));
	ptr_link_assertions i_ptr_link_assertions (.clock(clock), .rst(rst),
		.access_attention_n(link.access_attention_n),
		.multi_phase_flag_n(link.multi_phase_flag_n),
		.access_is_write(link.access_is_write),
		.pending_byte_lanes_n(link.pending_byte_lanes_n),
		.dq_dev_oe(link.dq_dev_oe), .address_fetch_n(link.address_fetch_n),
		.addon_phase_done_n(link.addon_phase_done_n),
		.reg_adr(link.reg_adr), .select_n(link.select_n), .wr_n(link.wr_n),
		.dq_usr_oe(link.dq_usr_oe));
	////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// word source; stall toggles valid so the add-on inserts waits
	always @(posedge clock) took <= src_valid && src_ready;
	always @(negedge clock) begin
		if (took) src_data = src_data + 32'h0000_0001;
		src_valid = stall ? ~src_valid : 1'b1;
	end
	// host drain checks supply order; packets counted at attention
	always @(negedge clock) begin
		host_pop = host_data_valid === 1'b1;
		if (host_pop) begin
			check_word("host_data", WORD_BASE + 32'(popped), host_data);
			popped = popped + 1;
		end
		if (attn_q === 1'b1 && link.access_attention_n === 1'b0) packets++;
		attn_q = link.access_attention_n;
	end
	task automatic check_word(input string name, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", name, e, g);
			fail_count++;
		end
	endtask : check_word
	task automatic check_num(input string name, input logic [7:0] e,
		input logic [7:0] g);
		check_word(name, {24'h0, e}, {24'h0, g});
	endtask : check_num
	// one host burst read, waited out, then judged
	task automatic run_read(input logic [31:0] a, input logic [1:0] r,
		input logic [7:0] n, input logic pf, input logic hit,
		input logic st, input logic fe, input int pk);
		int p0;
		int w0;
		@(negedge clock);
		p0 = packets;
		w0 = popped;
		host_addr = a;
		host_region = r;
		host_words = n;
		prefetch_en = pf;
		host_region_hit = hit;
		stall = st;
		want_address = fe;
		host_req = 1'b1;
		@(negedge clock);
		host_req = 1'b0;
		for (int i = 0; i < 400; i++) begin
			@(negedge clock);
			if (i > 4 && host_busy === 1'b0 && host_data_valid === 1'b0 &&
				link.access_attention_n === 1'b1) break;
		end
		repeat (2) @(negedge clock);
		check_num("words", hit ? n : 8'h00, 8'(popped - w0));
		check_num("packets", 8'(pk), 8'(packets - p0));
		if (hit) check_num("region", {6'h0, r}, {6'h0, got_region});
		if (fe) check_word("address", a, got_address);
	endtask : run_read
	task automatic burst_four_fetch;
		run_read(32'h0000_1230, 2'h1, 8'h04, 1, 1, 0, 1, 1);
	endtask : burst_four_fetch
	task automatic split_five;
		run_read(32'h0000_4560, 2'h2, 8'h05, 0, 1, 0, 0, 3);
	endtask : split_five
	task automatic stalled_four;
		run_read(32'h0000_7890, 2'h3, 8'h04, 1, 1, 1, 1, 1);
	endtask : stalled_four
	task automatic stalled_split;
		run_read(32'h0000_abc0, 2'h1, 8'h03, 0, 1, 1, 0, 2);
	endtask : stalled_split
	task automatic single_word;
		run_read(32'h0000_def0, 2'h0, 8'h01, 1, 1, 0, 1, 1);
	endtask : single_word
	task automatic region_miss;
		run_read(32'h0000_0ff0, 2'h2, 8'h04, 1, 0, 0, 0, 0);
	endtask : region_miss
	task automatic end_sim;
		if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	// main sequence after a six cycle reset
	initial begin
		{rst, attn_q} = 2'b11;
		{host_req, host_region_hit, prefetch_en, host_pop} = 4'h0;
		{src_valid, want_address, stall, took} = 4'h0;
		{host_addr, host_region, host_words} = '0;
		src_data = WORD_BASE;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		check_num("lanes", 8'h0f, {4'h0, link.pending_byte_lanes_n});
		burst_four_fetch();
		split_five();
		stalled_four();
		stalled_split();
		single_word();
		region_miss();
		end_sim();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		end_sim();
	end
endmodule : passthru_passive_burst_read_test
